// file: src/front_panel_defs.vh
/*
 Constants for the front-panel request and preset logic: register offsets,
 field positions, reset values and timing counts. Assumes a 125 MHz clock.
*/
// Operation
// R1: Knob turn gives low read strobes, 200-400ns.
// R2: Entry bit low while entry function active.
// R3: Knob clock fall starts 65-75ms low window.
// R4: Knob request rises as window ends, 100us-20ms.
// R5: Preset clears knob flag; pulse sweeping, hold otherwise.
// R6: No entry function, knob flag stays low.
// R7: Knob turn gives 100us low combined request.
// R8: Key press gives 100us low combined request.
// R9: Key press gives 100us key-down pulse; the code holds key_down_request_flag high until a preset.
// R10: Key press sets key flag; preset clears.
// R11: Preset lockout low unless remote.
// R12: Buffered preset key and inverted copy.
// R13: Preset key drives processor preset low.
// R14: Preset key drives indicator reset low.
// R15: Combined request merges knob and key pulses.
// R16: Lockout suppresses the preset path.
`ifndef FRONT_PANEL_DEFS_VH
`define FRONT_PANEL_DEFS_VH

`define CLK_MHZ            125
`define STROBE_MIN_NS      200
`define STROBE_CYCLES      ((`STROBE_MIN_NS * `CLK_MHZ + 999) / 1000)
`define WINDOW_MIN_MS      65
`define WINDOW_CYCLES      (`WINDOW_MIN_MS * `CLK_MHZ * 1000)
`define REQ_PULSE_US       100
`define REQ_PULSE_CYCLES   (`REQ_PULSE_US * `CLK_MHZ)

`define ADDR_CTRL          4'h0
`define ADDR_STATE         4'h4
`define ADDR_INT_STATUS    4'h8
`define ADDR_INT_MASK      4'hC

`define CTRL_ENTRY_BIT     0
`define CTRL_SWEEP_BIT     1
`define CTRL_REMOTE_BIT    2
`define CTRL_RESET         3'h0

`define EV_KNOB_BIT        0
`define EV_KEY_BIT         1
`define EV_PRESET_BIT      2
`define EV_RESET           3'h0

// Idle pin levels: preset released, no key held, knob clock high.
`define PIN_IDLE           3'h5

`endif

// file: src/front_panel_request_preset_logic.v
/*
 Front-panel request and preset logic: turns knob clock edges and key presses
 into service requests and buffers the preset key. Assumes the knob clock,
 key-down and preset key arrive asynchronously from the panel, and that
 software sets the entry, sweep and remote bits over the register port.
*/
`timescale 1ns/100ps
`include "front_panel_defs.vh"
module front_panel_request_preset_logic #(
	parameter WINDOW_CYCLES = `WINDOW_CYCLES,
	parameter REQ_CYCLES    = `REQ_PULSE_CYCLES
) (
	input  wire        clk,                       // 125 MHz clock.
	input  wire        reset_n,                   // Asynchronous reset.
	input  wire        knob_clk,                  // Rotary knob clock pin.
	input  wire        key_down,                  // Any key held, high.
	input  wire        preset_key_n,              // Preset key, low pressed.
	input  wire [3:0]  addr,                      // Register byte address.
	input  wire [31:0] wr_data,                   // Write data.
	input  wire        wr_en,                     // Write strobe.
	input  wire        rd_en,                     // Read strobe.
	output reg  [31:0] rd_data,                   // Read data, next cycle.
	output reg         knob_count_read_strobe_n,  // Count read strobe.
	output reg         knob_data_read_strobe_n,   // Data read strobe.
	output reg         entry_on_n,                // Low while entry active.
	output reg         count_window_n,            // Low during window.
	output reg         knob_request_flag,         // Knob request.
	output reg         key_down_request_flag,     // Key-down request.
	output reg         combined_request_n,        // Merged request.
	output reg         preset_lockout_bit,        // High in remote.
	output reg         preset_key_signal_n,       // Buffered preset key.
	output reg         preset_key_signal,         // Inverted copy.
	output reg         preset_to_processor_n,     // Preset to processor.
	output reg         indicator_reset_n,         // Indicator latch reset.
	output reg         irq                        // Interrupt, high.
);
	localparam WIN_W = 24;
	localparam REQ_W = 16;

	// Three stages per pin; a change counts once stages two and three agree.
	reg [2:0] s1_q;
	reg [2:0] s2_q;
	reg [2:0] s3_q;
	reg [2:0] pin_q;
	reg [2:0] pin_prev_q;

	reg [2:0] ctrl_q;
	reg [2:0] int_status_q;
	reg [2:0] int_mask_q;
	reg       knob_hold_q;
	reg       key_hold_q;
	reg       win_prev_q;

	// Write hit on one register; every writable register uses it.
	function wr_hit;
		input       we;
		input [3:0] a;
		input [3:0] target;
		begin
			wr_hit = we && (a == target);
		end
	endfunction

	// Read mux; unmapped offsets read as zero.
	function [31:0] read_word;
		input [3:0] a;
		input [2:0] ctrl;
		input [5:0] state;
		input [2:0] status;
		input [2:0] mask;
		begin
			case (a)
			`ADDR_CTRL:       read_word = {29'h0, ctrl};
			`ADDR_STATE:      read_word = {26'h0, state};
			`ADDR_INT_STATUS: read_word = {29'h0, status};
			`ADDR_INT_MASK:   read_word = {29'h0, mask};
			default:          read_word = 32'h00000000;
			endcase
		end
	endfunction

	// A synchronised pin moves only when stages two and three agree.
	function [2:0] settle;
		input [2:0] late;
		input [2:0] later;
		input [2:0] held;
		begin
			settle = (late & later) | (held & (late ^ later));
		end
	endfunction

	// Edge detectors shared by the pins and the window timer.
	function went_low;
		input prev;
		input now;
		begin
			went_low = prev & ~now;
		end
	endfunction

	function went_high;
		input prev;
		input now;
		begin
			went_high = ~prev & now;
		end
	endfunction

	wire knob_lvl    = pin_q[0];
	wire key_lvl     = pin_q[1];
	wire preset_lvl  = ~pin_q[2];
	wire knob_fall   = went_low(pin_prev_q[0], pin_q[0]);
	wire key_rise    = went_high(pin_prev_q[1], pin_q[1]);
	wire entry_on    = ctrl_q[`CTRL_ENTRY_BIT];
	wire sweeping    = ctrl_q[`CTRL_SWEEP_BIT];
	wire remote      = ctrl_q[`CTRL_REMOTE_BIT];
	wire strobe_act;
	wire win_act;
	wire knob_pulse;
	wire key_pulse;
	wire win_end     = went_low(win_prev_q, win_act);
	wire knob_event  = win_end & entry_on;                             // R6
	wire preset_eff  = preset_lvl & ~remote;                           // R16
	wire [2:0] events;
	wire [2:0] w1c;
	wire [5:0] state_word;

	assign events     = {preset_eff, key_rise, knob_event};
	assign w1c        = wr_hit(wr_en, addr, `ADDR_INT_STATUS) ? wr_data[2:0] : 3'h0;
	assign state_word = {preset_lvl, key_lvl, knob_lvl, win_act, key_hold_q, knob_hold_q};

	// Only stage two reads stage one, which may still be settling.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s1_q <= `PIN_IDLE;
			s2_q <= `PIN_IDLE;
			s3_q <= `PIN_IDLE;
		end else begin
			s1_q <= {preset_key_n, key_down, knob_clk};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Idle levels at reset keep the edge detectors from seeing a false edge.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_q      <= `PIN_IDLE;
			pin_prev_q <= `PIN_IDLE;
		end else begin
			pin_q      <= settle(s2_q, s3_q, pin_q);
			pin_prev_q <= pin_q;
		end
	end

	// Twenty-five clocks of 8 ns give the 200 ns minimum strobe width.
	pulse_timer #(.WIDTH(8), .COUNT(`STROBE_CYCLES)) u_strobe (
		.clk     (clk),
		.reset_n (reset_n),
		.trig    (knob_fall),
		.active  (strobe_act)
	);

	// A later step restarts the window, so a fast turn gives one request.
	pulse_timer #(.WIDTH(WIN_W), .COUNT(WINDOW_CYCLES)) u_window (
		.clk     (clk),
		.reset_n (reset_n),
		.trig    (knob_fall),
		.active  (win_act)
	);

	// One timed request per window end, only while an entry is active.
	pulse_timer #(.WIDTH(REQ_W), .COUNT(REQ_CYCLES)) u_knob_req (
		.clk     (clk),
		.reset_n (reset_n),
		.trig    (knob_event),
		.active  (knob_pulse)
	);

	// One timed request per key stroke, however long the key is held.
	pulse_timer #(.WIDTH(REQ_W), .COUNT(REQ_CYCLES)) u_key_req (
		.clk     (clk),
		.reset_n (reset_n),
		.trig    (key_rise),
		.active  (key_pulse)
	);

	// Control bits: entry active, sweeping and remote, as software last wrote them.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_q <= `CTRL_RESET;
		end else if (wr_hit(wr_en, addr, `ADDR_CTRL)) begin
			ctrl_q <= wr_data[2:0];
		end
	end

	// Mask bits select which sticky events drive the interrupt.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			int_mask_q <= `EV_RESET;
		end else if (wr_hit(wr_en, addr, `ADDR_INT_MASK)) begin
			int_mask_q <= wr_data[2:0];
		end
	end

	// Sticky events. A new event wins over a clear in the same cycle, so a
	// request that lands while software acknowledges the last one is not lost.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			int_status_q <= `EV_RESET;
		end else begin
			int_status_q <= (int_status_q & ~w1c) | events;
		end
	end

	// Read data stand for one cycle only and are zero otherwise, so a bus that
	// ORs several slaves together needs no extra gating here.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_data <= 32'h00000000;
		end else if (rd_en) begin
			rd_data <= read_word(addr, ctrl_q, state_word, int_status_q, int_mask_q);
		end else begin
			rd_data <= 32'h00000000;
		end
	end

	// The falling window marks the end of a burst of knob steps.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			win_prev_q <= 1'b0;
		end else begin
			win_prev_q <= win_act;
		end
	end

	// Holding only outside a sweep lets a sweep see a clean pulse per turn.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			knob_hold_q <= 1'b0;
		end else if (knob_event && !sweeping) begin
			knob_hold_q <= 1'b1;                                     // R5
		end else if (preset_eff) begin
			knob_hold_q <= 1'b0;                                     // R5
		end
	end

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			key_hold_q <= 1'b0;
		end else if (key_rise) begin
			key_hold_q <= 1'b1;                                      // R10
		end else if (preset_eff) begin
			key_hold_q <= 1'b0;                                      // R10
		end
	end

	// Both read strobes share one timer; they open the count and data
	// buffers together for every knob step.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			knob_count_read_strobe_n <= 1'b1;
			knob_data_read_strobe_n  <= 1'b1;
		end else begin
			knob_count_read_strobe_n <= ~strobe_act;                 // R1
			knob_data_read_strobe_n  <= ~strobe_act;                 // R1
		end
	end

	// Mirrors of the entry and remote control bits toward the panel.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			entry_on_n         <= 1'b1;
			preset_lockout_bit <= 1'b0;
		end else begin
			entry_on_n         <= ~entry_on;                         // R2
			preset_lockout_bit <= remote;                            // R11
		end
	end

	// The window output is stretched by one cycle, so that it returns high on
	// the very edge at which the knob request rises.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count_window_n <= 1'b1;
		end else begin
			count_window_n <= ~(win_act | win_prev_q);               // R3 R4
		end
	end

	// The knob flag follows the timed pulse and, outside a sweep, the hold.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			knob_request_flag <= 1'b0;
		end else begin
			knob_request_flag <= knob_pulse | knob_hold_q;           // R4 R5
		end
	end

	// The key flag rises with the stroke and stays until a preset.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			key_down_request_flag <= 1'b0;
		end else begin
			key_down_request_flag <= key_pulse | key_hold_q;         // R9
		end
	end

	// The merged request carries only the timed pulses, never the holds, so
	// the processor sees one low pulse per key stroke and per knob window end while an entry is active.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			combined_request_n <= 1'b1;
		end else begin
			combined_request_n <= ~(knob_pulse | key_pulse);         // R7 R8 R15
		end
	end

	// The raw copies follow the key even in remote so that software can still
	// see it; only the paths that act on the instrument are locked out.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			preset_key_signal_n <= 1'b1;
			preset_key_signal   <= 1'b0;
		end else begin
			preset_key_signal_n <= ~preset_lvl;                      // R12
			preset_key_signal   <= preset_lvl;                       // R12
		end
	end

	// Gated preset paths toward the processor and the indicator latches.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			preset_to_processor_n <= 1'b1;
			indicator_reset_n     <= 1'b1;
		end else begin
			preset_to_processor_n <= ~preset_eff;                    // R13
			indicator_reset_n     <= ~preset_eff;                    // R14
		end
	end

	// The interrupt is a level, one cycle behind the status and mask registers.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(int_status_q & int_mask_q);
		end
	end
endmodule

// file: src/pulse_timer.v
/*
 Retriggerable one-shot: active for COUNT clocks after the last trigger.
 Assumes trig is synchronous to clk.
*/
`timescale 1ns/100ps
module pulse_timer #(
	parameter WIDTH = 24,
	parameter COUNT = 25
) (
	input  wire clk,      // System clock.
	input  wire reset_n,  // Asynchronous reset, active low.
	input  wire trig,     // Start or restart the pulse.
	output reg  active    // High for COUNT clocks.
);
	localparam integer     LAST_I = COUNT - 1;
	localparam [WIDTH-1:0] LAST   = LAST_I[WIDTH-1:0];
	reg [WIDTH-1:0] cnt_q;

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q  <= {WIDTH{1'b0}};
			active <= 1'b0;
		end else if (trig) begin
			cnt_q  <= LAST;
			active <= 1'b1;
		end else if (cnt_q != {WIDTH{1'b0}}) begin
			cnt_q <= cnt_q - 1'b1;
		end else begin
			active <= 1'b0;
		end
	end
endmodule

// file: tb/front_panel_sva.sv
/*
 Checker for the front-panel request and preset logic.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/100ps
module front_panel_sva (
	input wire logic clk,                      // Clock.
	input wire logic reset_n,                  // Reset, low.
	input wire logic knob_count_read_strobe_n, // Count strobe.
	input wire logic knob_data_read_strobe_n,  // Data strobe.
	input wire logic entry_on_n,               // Entry bit.
	input wire logic count_window_n,           // Window.
	input wire logic knob_request_flag,        // Knob flag.
	input wire logic key_down_request_flag,    // Key flag.
	input wire logic combined_request_n,       // Merged request.
	input wire logic preset_lockout_bit,       // Lockout.
	input wire logic preset_key_signal_n,      // Buffered key.
	input wire logic preset_key_signal,        // Inverted copy.
	input wire logic preset_to_processor_n,    // Processor preset.
	input wire logic indicator_reset_n         // Indicator reset.
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	chk_strobe_width: assert property ($fell(knob_count_read_strobe_n) |->
		##24 !knob_count_read_strobe_n ##1 knob_count_read_strobe_n) else $error("strobe width");
	chk_strobe_pair: assert property (knob_count_read_strobe_n == knob_data_read_strobe_n)
		else $error("strobes differ");
	chk_window_len: assert property ($fell(count_window_n) |-> ##39 !count_window_n)
		else $error("window short");
	chk_knob_rise: assert property ($rose(knob_request_flag) |->
		$rose(count_window_n) && !entry_on_n) else $error("knob request start");
	chk_req_width: assert property ($fell(combined_request_n) |->
		##9 !combined_request_n ##1 combined_request_n) else $error("request width");
	chk_key_merge: assert property ($rose(key_down_request_flag) |-> !combined_request_n)
		else $error("key request not merged");
	chk_lockout_gate: assert property (preset_lockout_bit && $past(preset_lockout_bit) |->
		preset_to_processor_n) else $error("preset passed in remote");
	chk_preset_copy: assert property (preset_key_signal == !preset_key_signal_n)
		else $error("preset copy");
	chk_reset_pair: assert property (indicator_reset_n == preset_to_processor_n)
		else $error("indicator reset");
	cover property ($rose(knob_request_flag));
	cover property ($rose(key_down_request_flag));
	cover property ($fell(preset_to_processor_n));
endmodule

// file: tb/panel_model.sv
/*
 Panel model: a knob step and a key stroke as timed pin pulses.
 Assumes turn and press are one-cycle requests from the bench.
*/
`timescale 1ns/100ps
module panel_model (
	input  wire logic clk,          // Clock.
	input  wire logic turn,         // One knob step.
	input  wire logic press,        // One key stroke.
	input  wire logic preset_hold,  // Preset key held.
	output wire logic knob_clk,     // Knob clock pin.
	output wire logic key_down,     // Key pin.
	output wire logic preset_key_n  // Preset pin.
);
	int k = 0;
	int p = 0;
	// Pins hold for eight cycles so the three-flop sync sees each change.
	always @(posedge clk) begin
		k <= turn ? 8 : (k > 0 ? k - 1 : 0);
		p <= press ? 8 : (p > 0 ? p - 1 : 0);
	end
	assign knob_clk = (k == 0);
	assign key_down = (p != 0);
	assign preset_key_n = !preset_hold;
endmodule

// file: tb/tb_top.sv
/*
 Testbench: drives the register port and the panel model; reads are
 checked through an expectation queue. Assumes a 125 MHz clock.
*/
`timescale 1ns/100ps
module tb_top;
	logic clk = 0, reset_n = 0, turn = 0, press = 0, hold = 0;
	logic wr_en = 0, rd_en = 0, rd_seen_q = 0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wr_data = 32'h0, rnd = 32'h00014D60, e;
	logic [31:0] q[$];
	int n_errors = 0, n_tests = 0;
	wire knob_clk, key_down, preset_key_n, knob_count_read_strobe_n, knob_data_read_strobe_n;
	wire entry_on_n, count_window_n, knob_request_flag, key_down_request_flag, irq;
	wire combined_request_n, preset_lockout_bit, preset_key_signal_n, preset_key_signal;
	wire preset_to_processor_n, indicator_reset_n;
	wire [31:0] rd_data;
	initial forever #4 clk = ~clk;
	panel_model i_panel (.clk, .turn, .press, .preset_hold(hold), .knob_clk, .key_down,
		.preset_key_n);
	front_panel_request_preset_logic #(.WINDOW_CYCLES(40), .REQ_CYCLES(10)) i_dut (.clk,
		.reset_n, .knob_clk, .key_down, .preset_key_n, .addr, .wr_data, .wr_en, .rd_en,
		.rd_data, .knob_count_read_strobe_n, .knob_data_read_strobe_n, .entry_on_n,
		.count_window_n, .knob_request_flag, .key_down_request_flag, .combined_request_n,
		.preset_lockout_bit, .preset_key_signal_n, .preset_key_signal,
		.preset_to_processor_n, .indicator_reset_n, .irq);
	task check(input logic [31:0] got, input logic [31:0] x);
		n_tests++;
		if (got !== x) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, x);
		end
	endtask
	task report_and_stop;
		$display("Checks %0d, errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1;
		@(posedge clk);
		wr_en <= 0;
	endtask
	task rd(input logic [3:0] a, input logic [31:0] x);
		q.push_back(x);
		@(posedge clk);
		addr <= a;
		rd_en <= 1;
		@(posedge clk);
		rd_en <= 0;
	endtask
	task wait_for(input int sel);
		int i;
		for (i = 0; i < 200 && (sel ? key_down_request_flag : knob_request_flag) !== 1; i++)
			idle(1);
		if (i == 200) begin
			n_errors++;
			report_and_stop();
		end
	endtask
	function logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	// Read data stand only in the cycle after the strobe, so sample exactly there.
	always @(posedge clk) begin
		if (rd_seen_q) begin
			e = q.pop_front();
			check(rd_data, e);
		end
		rd_seen_q <= rd_en;
	end
	initial begin
		repeat (10) @(posedge clk);
		reset_n <= 1;
		rd(4'h0, 32'h0);
		rd(4'h2, 32'h0);
		check(preset_lockout_bit, 0);
		turn <= 1;
		idle(1);
		turn <= 0;
		idle(80);
		check(knob_request_flag, 0);
		wr(4'h0, 32'h1);
		idle(2);
		check(entry_on_n, 0);
		turn <= 1;
		idle(1);
		turn <= 0;
		wait_for(0);
		check(combined_request_n, 0);
		idle(20);
		check(knob_request_flag, 1);
		rd(4'h4, 32'h9);
		wr(4'hC, 32'h1);
		rd(4'h8, 32'h1);
		idle(2);
		check(irq, 1);
		wr(4'h8, 32'h1);
		idle(2);
		check(irq, 0);
		press <= 1;
		idle(1);
		press <= 0;
		wait_for(1);
		check(combined_request_n, 0);
		idle(20);
		check(key_down_request_flag, 1);
		check(irq, 0);
		wr(4'hC, 32'h3);
		idle(2);
		check(irq, 1);
		wr(4'h8, 32'h2);
		hold <= 1;
		idle(10);
		check(preset_to_processor_n, 0);
		check(indicator_reset_n, 0);
		check(preset_key_signal, 1);
		hold <= 0;
		idle(10);
		check(knob_request_flag, 0);
		check(key_down_request_flag, 0);
		wr(4'h0, 32'h5);
		idle(2);
		check(preset_lockout_bit, 1);
		hold <= 1;
		idle(10);
		check(preset_to_processor_n, 1);
		check(preset_key_signal_n, 0);
		hold <= 0;
		idle(10);
		wr(4'h0, 32'h3);
		turn <= 1;
		idle(1);
		turn <= 0;
		wait_for(0);
		idle(20);
		check(knob_request_flag, 0);
		for (int i = 0; i < 4; i++) begin
			rnd = xs(rnd);
			wr(4'hC, rnd);
			rd(4'hC, rnd & 32'h7);
		end
		idle(4);
		report_and_stop();
	end
endmodule
bind front_panel_request_preset_logic front_panel_sva i_chk (.clk, .reset_n,
	.knob_count_read_strobe_n, .knob_data_read_strobe_n, .entry_on_n, .count_window_n,
	.knob_request_flag, .key_down_request_flag, .combined_request_n, .preset_lockout_bit,
	.preset_key_signal_n, .preset_key_signal, .preset_to_processor_n, .indicator_reset_n);
